// ### inc/rsq_pkg.sv
// Shared constants and types for the repeat sweep priority sequencer.
// Assumes a single system clock and an external analog front end with a
// start/done handshake.
package rsq_pkg;
    localparam int RSQ_NUM_RESULTS = 8;
    localparam int RSQ_RESULT_W = 10;
    localparam int RSQ_CH_W = 3;
    localparam logic [1:0] RSQ_WIDTH_RST = 2'h0;
    localparam logic [1:0] RSQ_GROUP_RST = 2'h0;
    localparam logic [RSQ_CH_W-1:0] RSQ_PRIORITY_CH = 3'h0;
    localparam logic [RSQ_CH_W-1:0] RSQ_GROUP_BASE_STEP = 3'h4;
    localparam logic [RSQ_RESULT_W-1:0] RSQ_RESULT_RST = 10'h000;
    localparam logic RSQ_TRIG_IDLE = 1'b1;
    localparam logic RSQ_PRIO_FIRST = 1'b1;
    localparam logic [1:0] RSQ_FIRST_OTHER = 2'h1;
    localparam logic [1:0] RSQ_WIDTH_PRIO_ONLY = 2'h0;

    typedef enum logic [1:0] {
        RSQ_TRIG_SOFT = 2'h0,
        RSQ_TRIG_HARD = 2'h1
    } rsq_trig_e;

    typedef struct packed {
        logic conv_start_bit;
        logic trigger_source_sel;
        logic [1:0] sweep_width_sel;
        logic [1:0] input_group_sel;
    } rsq_ctrl_s;

    typedef struct packed {
        logic start;
        logic [RSQ_CH_W-1:0] channel;
    } rsq_conv_req_s;
endpackage

// ### logic/rsq_sequencer.sv
// Sequencer for repeat sweep mode with one priority input.
// Assumes the converter front end takes a one-cycle start with a channel
// and returns a one-cycle done with the result; all inputs but resetn synchronous.

// What this block does
// R1: Selected inputs are converted repeatedly with the priority input between each other input.
// R2: The swept set comes from the sweep width field and the input group field.
// R3: The sweep width picks input 0 only, 0 to 1, 0 to 2, or 0 to 3.
// R4: Software keeps all swept inputs inside one group.
// R5: With software trigger, the sweep starts when the start bit is set.
// R6: With hardware trigger, the sweep starts on a trigger pin fall after the start bit is set.
// R7: Converting stops only when software clears the start bit.
// R8: No conversion-complete interrupt is ever raised in this mode.
// R9: Each result goes to the result register of the converted input.
// R10: A new conversion of an input overwrites that input's result register.
module rsq_sequencer
    import rsq_pkg::*;
#(
    parameter int RESULT_W = RSQ_RESULT_W
) (
    input wire logic core_clk, // System clock, 25 MHz.
    input wire logic resetn, // Asynchronous reset, active low.
    input wire rsq_ctrl_s ctrl, // Control bits from software.
    input wire logic ext_conv_trigger_pin, // External trigger, falling edge.
    input wire logic conv_done, // Converter finished, one-cycle pulse.
    input wire logic [RESULT_W-1:0] conv_data, // Result with conv_done.
    output rsq_conv_req_s conv_req, // Start pulse and channel to convert.
    output logic busy, // High while the sweep runs.
    output logic conv_irq, // Conversion-complete request, held low.
    output logic [RSQ_NUM_RESULTS-1:0][RESULT_W-1:0] conv_result_regs // Results.
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_ISSUE,
        ST_WAIT
    } rsq_state_e;

    // Sweep state and trigger history.
    rsq_state_e state_reg;
    logic trig_prev_reg;
    logic prio_turn_reg;
    logic [1:0] other_idx_reg;
    logic [RSQ_CH_W-1:0] cur_ch_reg;

    // Decoded control and the channel chosen for the next issue.
    logic run_req;
    logic hard_sel;
    logic [1:0] width_sel;
    logic prio_only;
    logic [RSQ_CH_W-1:0] group_base;
    logic [RSQ_CH_W-1:0] prio_ch;
    logic [1:0] other_cur;
    logic [RSQ_CH_W-1:0] other_ch;
    logic other_wrap;
    logic take_prio;
    logic [RSQ_CH_W-1:0] issue_ch;
    logic [1:0] other_next;

    // Sequencing events.
    logic trig_fall;
    logic in_rest;
    logic in_issue;
    logic in_wait;
    logic issue_ok;
    logic done_taken;
    logic [RSQ_NUM_RESULTS-1:0] res_wr_en;

    assign run_req = ctrl.conv_start_bit; // R5 R7
    assign hard_sel = (2'(ctrl.trigger_source_sel) == RSQ_TRIG_HARD); // R6
    assign width_sel = ctrl.sweep_width_sel; // R2
    assign prio_only = (width_sel == RSQ_WIDTH_PRIO_ONLY); // R3

    // The group field offsets every channel, so one group is always used.
    assign group_base = RSQ_CH_W'(ctrl.input_group_sel) * RSQ_GROUP_BASE_STEP; // R2 R4
    assign prio_ch = group_base + RSQ_PRIORITY_CH; // R1
    // A width lowered mid-sweep below the next other input sends that turn back to the first one.
    assign other_cur = (other_idx_reg > width_sel) ? RSQ_FIRST_OTHER : other_idx_reg; // R3
    assign other_ch = group_base + RSQ_CH_W'(other_cur); // R2
    assign other_wrap = (other_cur >= width_sel); // R3
    // With width zero only the priority input is converted, so no interleave.
    assign take_prio = prio_turn_reg || prio_only; // R1 R3
    assign issue_ch = take_prio ? prio_ch : other_ch; // R1
    assign other_next = other_wrap ? RSQ_FIRST_OTHER : other_cur + 2'h1; // R3

    // History resets to the idle high level so reset release is no fall.
    assign trig_fall = trig_prev_reg && !ext_conv_trigger_pin; // R6
    // Rest states hold the sweep position at its start.
    assign in_rest = (state_reg == ST_IDLE) || (state_reg == ST_ARMED);
    assign in_issue = (state_reg == ST_ISSUE);
    assign in_wait = (state_reg == ST_WAIT);
    // An issue cut short by a cleared start bit sends no pulse.
    assign issue_ok = in_issue && run_req; // R7
    // A done outside the wait state belongs to no issued conversion.
    assign done_taken = in_wait && conv_done; // R9

    // Previous pin level for the falling-edge detector.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            trig_prev_reg <= RSQ_TRIG_IDLE;
        end else begin
            trig_prev_reg <= ext_conv_trigger_pin;
        end
    end

    // Clearing the start bit wins over every other transition.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
        end else if (!run_req) begin
            state_reg <= ST_IDLE; // R7
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (hard_sel) begin
                        state_reg <= ST_ARMED; // R6
                    end else begin
                        state_reg <= ST_ISSUE; // R5
                    end
                end
                ST_ARMED: begin
                    if (!hard_sel) begin
                        state_reg <= ST_ISSUE; // R5
                    end else if (trig_fall) begin
                        state_reg <= ST_ISSUE; // R6
                    end
                end
                ST_ISSUE: begin
                    state_reg <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (conv_done) begin
                        state_reg <= ST_ISSUE; // R1
                    end
                end
            endcase
        end
    end

    // Priority turn alternates on every issue and restarts high when idle.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prio_turn_reg <= RSQ_PRIO_FIRST;
        end else if (in_rest) begin
            prio_turn_reg <= RSQ_PRIO_FIRST;
        end else if (in_issue) begin
            prio_turn_reg <= !prio_turn_reg; // R1
        end
    end

    // Only an issue of an other input moves on to the next other input.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            other_idx_reg <= RSQ_FIRST_OTHER;
        end else if (in_rest) begin
            other_idx_reg <= RSQ_FIRST_OTHER;
        end else if (in_issue && !take_prio) begin
            other_idx_reg <= other_next; // R1 R3
        end
    end

    // Channel of the conversion in flight, used to steer its result.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cur_ch_reg <= RSQ_PRIORITY_CH;
        end else if (in_issue) begin
            cur_ch_reg <= issue_ch; // R9
        end
    end

    // One start pulse per issue with the start bit still set; the channel holds until the next issue.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            conv_req.start <= 1'b0;
            conv_req.channel <= RSQ_PRIORITY_CH;
        end else begin
            conv_req.start <= issue_ok; // R1 R5
            if (in_issue) begin
                conv_req.channel <= issue_ch; // R1 R2
            end
        end
    end

    // Busy drops on the first edge that sees the start bit cleared.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            busy <= 1'b0;
        end else begin
            busy <= run_req && (in_issue || in_wait); // R7
        end
    end

    // The sweep never raises the completion request.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            conv_irq <= 1'b0;
        end else begin
            conv_irq <= 1'b0; // R8
        end
    end

    // One result entry per input; a done writes only the entry in flight.
    genvar gi;
    generate
        for (gi = 0; gi < RSQ_NUM_RESULTS; gi++) begin : g_res
            localparam logic [RSQ_CH_W-1:0] ENTRY_CH = RSQ_CH_W'(gi);
            logic entry_hit;

            // The entry matches when the conversion in flight is its own input.
            assign entry_hit = (cur_ch_reg == ENTRY_CH);
            assign res_wr_en[gi] = done_taken && entry_hit; // R9
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    conv_result_regs[gi] <= RESULT_W'(RSQ_RESULT_RST);
                end else if (res_wr_en[gi]) begin
                    conv_result_regs[gi] <= conv_data; // R9 R10
                end
            end
        end
    endgenerate
endmodule

// ### verification/rsq_conv_model.sv
// Converter front end model answering start pulses after a random delay.
// Assumes the bench seeds the random generator once.
module rsq_conv_model
    import rsq_pkg::*;
(
    input wire logic core_clk, // System clock.
    input wire rsq_conv_req_s conv_req, // Start pulse and channel.
    output logic conv_done, // One-cycle completion.
    output logic [RSQ_RESULT_W-1:0] conv_data // Result, toggles when not valid.
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = -1;
    initial {conv_done, conv_data} = '0;
    always @(posedge core_clk) begin
        conv_done <= 1'b0;
        conv_data <= ~conv_data;
        if (conv_req.start) cnt <= $urandom_range(5, 0);
        else if (cnt == 0) {conv_done, conv_data, cnt} <= {1'b1, 10'($urandom), 32'hffffffff};
        else if (cnt > 0) cnt <= cnt - 1;
    end
endmodule

// ### verification/rsq_sequencer_properties.sv
// Checker for the sweep sequencer, bound to its ports.
// Assumes one clock domain and the asynchronous active-low reset.
module rsq_sequencer_properties
    import rsq_pkg::*;
#(parameter int RESULT_W = RSQ_RESULT_W) (
    input wire logic core_clk, resetn, ext_conv_trigger_pin, conv_done, busy, conv_irq,
    input wire rsq_ctrl_s ctrl,
    input wire logic [RESULT_W-1:0] conv_data,
    input wire rsq_conv_req_s conv_req,
    input wire logic [RSQ_NUM_RESULTS-1:0][RESULT_W-1:0] conv_result_regs
);
    logic pin_q, fall_q, fall_qq, last_np;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) {pin_q, fall_q, fall_qq, last_np} <= 4'h8;
        else begin
            {pin_q, fall_q, fall_qq} <= {ext_conv_trigger_pin, pin_q && !ext_conv_trigger_pin, fall_q};
            if (conv_req.start) last_np <= conv_req.channel[1:0] != 2'h0;
        end
    end
    sequence s_run_done; conv_done && busy && ctrl.conv_start_bit; endsequence
    property p_irq; conv_irq == 1'b0; endproperty
    property p_stop; !ctrl.conv_start_bit [*2] |-> !busy && !conv_req.start; endproperty
    property p_soft; $rose(ctrl.conv_start_bit) && !ctrl.trigger_source_sel |-> ##2 conv_req.start; endproperty
    property p_hard; ctrl.trigger_source_sel && $rose(busy) |-> fall_q || fall_qq; endproperty
    property p_prio; conv_req.start && last_np |-> conv_req.channel[1:0] == 2'h0; endproperty
    property p_range; conv_req.start |-> conv_req.channel[1:0] <= ctrl.sweep_width_sel
        && conv_req.channel[2] == ctrl.input_group_sel[0]; endproperty
    property p_pulse; conv_req.start |=> !conv_req.start; endproperty
    property p_result; s_run_done |=> conv_result_regs[conv_req.channel] == $past(conv_data); endproperty
    a_irq: assert property (p_irq) else $error("irq raised");
    a_stop: assert property (p_stop) else $error("no stop");
    a_soft: assert property (p_soft) else $error("no soft start");
    a_hard: assert property (p_hard) else $error("start without fall");
    a_prio: assert property (p_prio) else $error("priority skipped");
    a_range: assert property (p_range) else $error("bad channel");
    a_pulse: assert property (p_pulse) else $error("long pulse");
    a_result: assert property (p_result) else $error("result lost");
endmodule

// ### verification/adc_repeat_sweep_priority_sequencer_test.sv
// Self-checking bench for the sweep sequencer with a converter model.
// Assumes the checker and model files are compiled first.
module adc_repeat_sweep_priority_sequencer_test;
    import rsq_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 0, resetn = 0, ext_conv_trigger_pin = 1, conv_done, busy, conv_irq, pri = 1;
    rsq_ctrl_s ctrl = '0;
    rsq_conv_req_s conv_req;
    logic [RSQ_RESULT_W-1:0] conv_data, pdat;
    logic [RSQ_NUM_RESULTS-1:0][RSQ_RESULT_W-1:0] conv_result_regs;
    logic [2:0] base, pch;
    logic pend = 1'b0;
    int fails = 0, compares = 0, nxt = 1;
    always #20 core_clk = ~core_clk;
    rsq_sequencer rsq_sequencer_inst (.core_clk, .resetn, .ctrl, .ext_conv_trigger_pin,
        .conv_done, .conv_data, .conv_req, .busy, .conv_irq, .conv_result_regs);
    rsq_conv_model rsq_conv_model_inst (.core_clk, .conv_req, .conv_done, .conv_data);
    task automatic chk_ch(input logic [2:0] got, input logic [2:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %h %h", $time, got, exp);
        end
    endtask
    task automatic chk_res(input logic [9:0] got, input logic [9:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %h %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        if (fails == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        base = {ctrl.input_group_sel[0], 2'h0};
        if (pend) chk_res(conv_result_regs[pch], pdat);
        {pend, pch, pdat} = {conv_done && busy && ctrl.conv_start_bit, conv_req.channel, conv_data};
        if (conv_req.start) begin
            chk_ch(conv_req.channel, pri ? base : base + 3'(nxt));
            if (!pri) nxt = nxt >= ctrl.sweep_width_sel ? 1 : nxt + 1;
            pri = !pri || ctrl.sweep_width_sel == 2'h0;
        end
        if (!busy) {pri, nxt} = {1'b1, 32'h1};
    end
    task automatic run(input logic [1:0] g, input logic [1:0] w, input logic hard);
        ctrl = '{1'b1, hard, w, g};
        repeat (12) @(negedge core_clk);
        chk_ch({2'h0, busy}, {2'h0, !hard});
        ext_conv_trigger_pin = 1'b0;
        repeat (60) @(negedge core_clk);
        {ctrl.conv_start_bit, ext_conv_trigger_pin} = 2'h1;
        repeat (10) @(negedge core_clk);
        chk_ch({2'h0, busy}, 3'h0);
        chk_ch({2'h0, conv_irq}, 3'h0);
    endtask
    initial begin
        void'($urandom(32'hae32c005));
        repeat (16) @(negedge core_clk);
        resetn = 1'b1;
        foreach (conv_result_regs[i]) chk_res(conv_result_regs[i], RSQ_RESULT_RST);
        for (int i = 0; i < 16; i++) run(2'(i >> 2), 2'(i), 1'b0);
        run(2'($urandom), 2'($urandom), 1'b1);
        final_report();
    end
    initial begin
        #(40 * 5000);
        fails++;
        final_report();
    end
endmodule
bind rsq_sequencer rsq_sequencer_properties #(.RESULT_W(RESULT_W)) rsq_sequencer_properties_inst (
    .core_clk, .resetn, .ext_conv_trigger_pin, .conv_done, .busy, .conv_irq, .ctrl,
    .conv_data, .conv_req, .conv_result_regs);
